/* File: src/cra_pkg.sv */
// constants shared by the register access port
package cra_pkg;
  localparam int unsigned ADDR_W       = 6;
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned REG_COUNT    = 64;
  localparam logic [5:0]  RANK_LAT_LO  = 6'h10;
  localparam logic [5:0]  RANK_LAT_HI  = 6'h13;
  localparam logic [15:0] REG_RST_VAL  = 16'h0000;
  localparam logic [1:0]  SETTLE_CYCLES = 2'h3;
  localparam logic [1:0]  SETTLE_LAST  = 2'h1;

  typedef enum logic [1:0] {
    CRA_ST_IDLE   = 2'b01,
    CRA_ST_SETTLE = 2'b10
  } cra_state_t;
endpackage

/* File: src/cra_port.sv */
// register bank behind the shared register access port
`timescale 1ns/100ps
// Functional notes
// RULE1: write data lands in addressed register
// RULE2: master presents data with enable and select
// RULE3: writes go through shadow, committed later
// RULE4: ready flag shows next write acceptable
// RULE5: idle master drives write data zero
// RULE6: read data shows addressed register bits
// RULE7: read data appears cycle after read
// RULE8: calibration engine shares registers, ready shows contention
// RULE9: ready drops during write collision
// RULE10: collided external write completes without retry
// RULE11: master waits while ready flag low
// RULE12: rank latency writes hold ready low
// RULE13: no back-to-back rank latency accesses
// RULE14: write enable high for a write
// RULE15: nibble select high for any access
// RULE16: six-bit address selects register bits
// RULE17: idle master drives address zero
// RULE18: port runs on its own clock
// RULE19: ready high after reset when idle
// RULE20: calibration write first, shadow commit after
module cra_port (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  input  wire logic [5:0]  i_port_address,
  input  wire logic [15:0] i_port_write_data,
  input  wire logic        i_port_write_enable,
  input  wire logic        i_port_nibble_select,
  input  wire logic        i_cal_write_req,
  input  wire logic [5:0]  i_cal_address,
  input  wire logic [15:0] i_cal_write_data,
  output logic [15:0]      o_port_read_data,
  output logic             o_port_ready_flag
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [15:0]        mem_q [cra_pkg::REG_COUNT];
  logic               mem_we;
  logic [5:0]         mem_wa;
  logic [15:0]        mem_wd;
  logic               pend;
  logic [5:0]         sh_addr;
  logic [15:0]        sh_data;
  logic               wr_acc;
  logic               rd_acc;
  logic               commit;
  logic [15:0]        rd_word;
  logic [15:0]        rdata_q;
  logic [15:0]        rdata_d;
  cra_pkg::cra_state_t state_q;
  cra_pkg::cra_state_t state_d;
  logic [1:0]         cnt_q;
  logic [1:0]         cnt_d;

  function automatic logic is_rank_lat(input logic [5:0] a);
    return (a >= cra_pkg::RANK_LAT_LO) && (a <= cra_pkg::RANK_LAT_HI);
  endfunction

  // ----------------------------------------------------------------
  // handshake
  // ----------------------------------------------------------------
  // busy while a shadowed write is blocked, while a rank latency word
  // waits in the shadow, or while a slow update settles; holding off in
  // the commit cycle keeps a second rank latency access out entirely
  assign o_port_ready_flag = !(pend && i_cal_write_req) && // RULE9
                             !(pend && is_rank_lat(sh_addr)) && // RULE12
                             (state_q == cra_pkg::CRA_ST_IDLE); // RULE4
  assign wr_acc = o_port_ready_flag && i_port_write_enable &&
                  i_port_nibble_select;
  assign rd_acc = o_port_ready_flag && !i_port_write_enable &&
                  i_port_nibble_select;
  // calibration engine has the write port first
  assign commit = pend && !i_cal_write_req; // RULE20

  cra_shadow u_shadow (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_load    (wr_acc), // RULE3
    .i_addr    (i_port_address),
    .i_data    (i_port_write_data),
    .i_commit  (commit), // RULE10
    .o_pending (pend),
    .o_addr    (sh_addr),
    .o_data    (sh_data)
  );

  // ----------------------------------------------------------------
  // register array
  // ----------------------------------------------------------------
  always_comb begin
    mem_we = 1'b0;
    mem_wa = 6'h00;
    mem_wd = cra_pkg::REG_RST_VAL;
    if (i_cal_write_req) begin // RULE8
      mem_we = 1'b1;
      mem_wa = i_cal_address;
      mem_wd = i_cal_write_data;
    end else if (pend) begin // RULE1
      mem_we = 1'b1;
      mem_wa = sh_addr;
      mem_wd = sh_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin // RULE18
    if (!i_reset_n) begin
      for (int i = 0; i < cra_pkg::REG_COUNT; i++) begin
        mem_q[i] <= cra_pkg::REG_RST_VAL;
      end
    end else if (mem_we) begin
      mem_q[mem_wa] <= mem_wd;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  assign rd_word = mem_q[i_port_address];

  always_comb begin
    rdata_d = rdata_q;
    if (rd_acc) begin // RULE7
      rdata_d = rd_word; // RULE6
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      rdata_q <= cra_pkg::REG_RST_VAL;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_port_read_data = rdata_q;

  // ----------------------------------------------------------------
  // slow update of rank latency registers
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      cra_pkg::CRA_ST_IDLE: begin
        if (commit && is_rank_lat(sh_addr)) begin // RULE12
          state_d = cra_pkg::CRA_ST_SETTLE;
          cnt_d   = cra_pkg::SETTLE_CYCLES;
        end
      end
      cra_pkg::CRA_ST_SETTLE: begin
        cnt_d = cnt_q - 2'h1;
        if (cnt_q == cra_pkg::SETTLE_LAST) begin
          state_d = cra_pkg::CRA_ST_IDLE;
        end
      end
      default: begin
        state_d = cra_pkg::CRA_ST_IDLE;
        cnt_d   = 2'h0;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      state_q <= cra_pkg::CRA_ST_IDLE; // RULE19
      cnt_q   <= 2'h0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_ext_write_lands;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    wr_acc ##1 !i_cal_write_req |=>
      mem_q[$past(i_port_address, 2)] == $past(i_port_write_data, 2);
  endproperty
  a_ext_write_lands: assert property (p_ext_write_lands) // RULE1
    else $error("external write did not reach its register");

  property p_shadow_first;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    wr_acc |=> pend && (sh_addr == $past(i_port_address)) &&
               (sh_data == $past(i_port_write_data));
  endproperty
  a_shadow_first: assert property (p_shadow_first) // RULE3
    else $error("accepted write not held in shadow");

  property p_collision_busy;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (pend && i_cal_write_req) |-> !o_port_ready_flag;
  endproperty
  a_collision_busy: assert property (p_collision_busy) // RULE9
    else $error("ready high during write collision");

  property p_read_next;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    rd_acc |=> o_port_read_data == $past(rd_word);
  endproperty
  a_read_next: assert property (p_read_next) // RULE7
    else $error("read data wrong one cycle after read");

  property p_cal_write;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    i_cal_write_req |=>
      mem_q[$past(i_cal_address)] == $past(i_cal_write_data);
  endproperty
  a_cal_write: assert property (p_cal_write) // RULE8
    else $error("calibration write lost");

  property p_deferred_done;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (pend && !i_cal_write_req && !wr_acc) |=> !pend;
  endproperty
  a_deferred_done: assert property (p_deferred_done) // RULE10
    else $error("shadow write not committed once free");

  property p_cal_before_shadow;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (pend && i_cal_write_req) |=> pend && (sh_addr == $past(sh_addr));
  endproperty
  a_cal_before_shadow: assert property (p_cal_before_shadow) // RULE20
    else $error("shadow committed ahead of calibration write");

  property p_rank_slow;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (commit && is_rank_lat(sh_addr) &&
     state_q == cra_pkg::CRA_ST_IDLE) |=> !o_port_ready_flag [*3];
  endproperty
  a_rank_slow: assert property (p_rank_slow) // RULE12
    else $error("ready not held low after rank latency write");

  property p_ready_after_reset;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (!$past(i_reset_n) && !i_cal_write_req) |-> o_port_ready_flag;
  endproperty
  a_ready_after_reset: assert property (p_ready_after_reset) // RULE19
    else $error("ready low right after reset");

  property p_ready_idle;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (!pend && state_q == cra_pkg::CRA_ST_IDLE) |-> o_port_ready_flag;
  endproperty
  a_ready_idle: assert property (p_ready_idle) // RULE4
    else $error("ready low with nothing pending");
endmodule // cra_port

/* File: src/cra_shadow.sv */
// shadow holding register for accepted external writes
`timescale 1ns/100ps
module cra_shadow (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_load,
  input  wire logic [5:0]  i_addr,
  input  wire logic [15:0] i_data,
  input  wire logic        i_commit,
  output logic             o_pending,
  output logic [5:0]       o_addr,
  output logic [15:0]      o_data
);
  logic        pend_q;
  logic        pend_d;
  logic [5:0]  addr_q;
  logic [5:0]  addr_d;
  logic [15:0] data_q;
  logic [15:0] data_d;

  // a new load wins over the commit of the previous word
  always_comb begin
    pend_d = pend_q;
    addr_d = addr_q;
    data_d = data_q;
    if (i_commit) begin
      pend_d = 1'b0;
    end
    if (i_load) begin
      pend_d = 1'b1;
      addr_d = i_addr;
      data_d = i_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      pend_q <= 1'b0;
      addr_q <= 6'h00;
      data_q <= cra_pkg::REG_RST_VAL;
    end else begin
      pend_q <= pend_d;
      addr_q <= addr_d;
      data_q <= data_d;
    end
  end

  assign o_pending = pend_q;
  assign o_addr    = addr_q;
  assign o_data    = data_q;
endmodule // cra_shadow

/* File: test/cra_master.sv */
// register master model for the access port
`timescale 1ns/100ps
module cra_master (
  input  wire logic        i_ref_clk,
  input  wire logic        i_ready,
  output logic [5:0]       o_addr,
  output logic [15:0]      o_wdata,
  output logic             o_we,
  output logic             o_nsel
);
  task automatic idle();
    o_addr  = 6'h00;
    o_wdata = 16'h0000;
    o_we    = 1'b0;
    o_nsel  = 1'b0;
  endtask

  initial idle();

  // holds the request until an edge that sees ready high
  task automatic access(input logic w, input logic [5:0] a,
                        input logic [15:0] d);
    o_addr  = a;
    o_wdata = w ? d : 16'h0000;
    o_we    = w;
    o_nsel  = 1'b1;
    @(negedge i_ref_clk);
    while (!i_ready) @(negedge i_ref_clk);
    @(posedge i_ref_clk);
    #1;
  endtask
endmodule // cra_master

/* File: test/cra_port_test.sv */
// self-checking bench for the register access port
`timescale 1ns/100ps
module cra_port_test;
  logic        ref_clk;
  logic        reset_n;
  logic [5:0]  addr;
  logic [15:0] wdata;
  logic        we;
  logic        nsel;
  logic        cal_req;
  logic [5:0]  cal_addr;
  logic [15:0] cal_data;
  logic [15:0] rdata;
  logic        ready;
  int          num_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;

  cra_port uut (
    .i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_port_address(addr),
    .i_port_write_data(wdata), .i_port_write_enable(we),
    .i_port_nibble_select(nsel), .i_cal_write_req(cal_req),
    .i_cal_address(cal_addr), .i_cal_write_data(cal_data),
    .o_port_read_data(rdata), .o_port_ready_flag(ready)
  );

  cra_master m (
    .i_ref_clk(ref_clk), .i_ready(ready), .o_addr(addr),
    .o_wdata(wdata), .o_we(we), .o_nsel(nsel)
  );

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic finish_test();
    if (num_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      $display("unexpected at %0t: run timed out", $time);
      finish_test();
    end
  end

  // ---------------------------------
  // helpers
  // ---------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic rd(input logic [5:0] a, input logic [15:0] exp);
    m.access(1'b0, a, 16'h0000);
    chk(rdata, exp);
    m.idle();
    step();
  endtask

  // ---------------------------------
  // scenarios
  // ---------------------------------
  task automatic t_reset();
    chk({15'h0000, ready}, 16'h0001);
    rd(6'h05, cra_pkg::REG_RST_VAL);
  endtask

  task automatic t_write_read();
    m.access(1'b1, 6'h07, 16'habcd);
    rd(6'h07, 16'h0000);
    rd(6'h07, 16'habcd);
    m.access(1'b1, 6'h3f, 16'h8001);
    m.access(1'b1, 6'h00, 16'h7ffe);
    rd(6'h3f, 16'h8001);
    rd(6'h00, 16'h7ffe);
  endtask

  task automatic t_collision();
    m.access(1'b1, 6'h09, 16'h2222);
    m.idle();
    cal_addr = 6'h09;
    cal_data = 16'h1111;
    cal_req = 1'b1;
    @(negedge ref_clk);
    chk({15'h0000, ready}, 16'h0000);
    step();
    cal_req = 1'b0;
    @(negedge ref_clk);
    chk({15'h0000, ready}, 16'h0001);
    step();
    rd(6'h09, 16'h2222);
    cal_addr = 6'h0a;
    cal_req = 1'b1;
    step();
    cal_req = 1'b0;
    rd(6'h0a, 16'h1111);
  endtask

  task automatic t_rank();
    logic [5:0] a;
    logic       slow;
    int         t0;
    for (int i = 0; i < 6; i++) begin
      a = 6'h0f + 6'(i);
      slow = a >= cra_pkg::RANK_LAT_LO && a <= cra_pkg::RANK_LAT_HI;
      m.access(1'b1, a, 16'h00f0 + 16'(i));
      m.idle();
      for (int c = 0; c < 5; c++) begin
        @(negedge ref_clk);
        chk({15'h0000, ready}, {15'h0000, !(slow && c < 4)});
      end
      step();
    end
    rd(6'h10, 16'h00f1);
    m.access(1'b1, 6'h11, 16'h0a0a);
    t0 = cycles;
    m.access(1'b1, 6'h12, 16'h0b0b);
    chk(16'(cycles - t0), 16'(cra_pkg::SETTLE_CYCLES) + 16'h0002);
    rd(6'h11, 16'h0a0a);
    rd(6'h12, 16'h0b0b);
  endtask

  initial begin
    reset_n = 1'b0;
    cal_req = 1'b0;
    cal_addr = 6'h00;
    cal_data = 16'h0000;
    repeat (6) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    t_reset();
    t_write_read();
    t_collision();
    t_rank();
    finish_test();
  end
endmodule // cra_port_test
